// ===== hdl/strap_pkg.sv
// Constants for the strap and pin-function select block
package strap_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 250000000; // System clock rate
    localparam int unsigned LINK_START_MS = 80; // Latest link training start after reset
    localparam longint unsigned LINK_START_CYCLES_L =
        (longint'(CLK_FREQ_HZ) * LINK_START_MS) / 1000; // Round down
    localparam logic [31:0] LINK_START_CYCLES = LINK_START_CYCLES_L[31:0];
    localparam logic [31:0] LINK_START_DELAY = 32'h0000_0010; // Cycles before training start
    // ----------------------------------------
    // Clock frequency codes
    // ----------------------------------------
    localparam logic CLK_SEL_50MHZ = 1'b0; // Strap low selects 50 MHz
    localparam logic CLK_SEL_66MHZ = 1'b1; // Strap high selects 66 MHz
    // ----------------------------------------
    // Strap vector field positions
    // ----------------------------------------
    localparam int STRAP_SCL_PULLUP = 0;
    localparam int STRAP_CLK_SEL = 1;
    localparam int STRAP_IRQ_PULLUP = 2; // Pull-up sensed on serial interrupt pin
    localparam int STRAP_WIDTH = 3;
    localparam logic [2:0] STRAP_RESET = 3'h0; // Latched strap value during reset
    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN = 3'b100
    } seq_state_type;
endpackage

// ===== hdl/pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
module pin_sync
    import strap_pkg::*;
#(
    parameter int WIDTH = 1
)(
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    // ----------------------------------------
    // Synchroniser stages
    // ----------------------------------------
    logic [WIDTH-1:0] meta_reg; // First stage, read only by second
    logic [WIDTH-1:0] s2_reg; // Second stage
    logic [WIDTH-1:0] s3_reg; // Third stage
    logic [WIDTH-1:0] out_reg; // Filtered value
    wire [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg); // Stages two and three agree

    // Shift and update on agreement
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            meta_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            out_reg <= '0;
        end
        else
        begin
            meta_reg <= i_async;
            s2_reg <= meta_reg;
            s3_reg <= s2_reg;
            out_reg <= (agree & s3_reg) | (~agree & out_reg);
        end
    end

    assign o_sync = out_reg;
endmodule

// ===== hdl/strap_pin_function_select.sv
// Strap sampling, shared-pin function select and reset sequencing
`timescale 1ns/1ns
module strap_pin_function_select
    import strap_pkg::*;
#(
    parameter logic [31:0] LINK_CYCLES = LINK_START_DELAY // Shortenable, max LINK_START_CYCLES
)(
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_global_reset_in_n,
    input wire logic i_scl_pullup_sense,
    input wire logic i_pci_clock_freq_strap,
    input wire logic i_serial_interrupt_pin,
    input wire logic i_serial_bus_detect_bit,
    input wire logic [1:0] i_gpio_dir_in,
    output logic o_serial_data_sel,
    output logic o_serial_clock_sel,
    output logic o_general_io_line_three_sel,
    output logic o_general_io_line_four_sel,
    output logic [1:0] o_gpio_pullup_en,
    output logic o_pci_clock_outputs_66,
    output logic o_serial_interrupt_en,
    output logic o_secondary_bus_reset_out_n,
    output logic o_link_train_start,
    output logic o_logic_reset
);
    // ----------------------------------------
    // Input synchronisation
    // ----------------------------------------
    logic [3:0] pins_sync; // Synchronised reset and strap pins
    pin_sync #(
        .WIDTH(4)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_async({i_serial_interrupt_pin, i_pci_clock_freq_strap,
                  i_scl_pullup_sense, i_global_reset_in_n}),
        .o_sync(pins_sync)
    );
    wire glob_rst_n = pins_sync[0]; // Filtered global reset, active low
    wire [STRAP_WIDTH-1:0] strap_now = pins_sync[3:1]; // Current strap levels

    // ----------------------------------------
    // State and registers
    // ----------------------------------------
    seq_state_type state_reg; // Reset sequencer
    seq_state_type state_next;
    logic [STRAP_WIDTH-1:0] strap_reg; // Latched straps
    logic [31:0] cnt_reg; // Training start counter
    logic [31:0] cnt_next;
    // Output flops, one per top-level output
    logic data_sel_reg; // Data pin in serial role
    logic clock_sel_reg; // Clock pin in serial role
    logic line_three_reg; // Data pin in general I/O role
    logic line_four_reg; // Clock pin in general I/O role
    logic [1:0] pullup_reg; // Pull-up enables, bit 0 line three
    logic clk66_reg; // PCI clock outputs at 66 MHz when set; reset gives 50 MHz
    logic irq_en_reg; // Serial interrupt interface enabled
    logic bus_rst_n_reg; // Secondary bus reset, active low
    logic train_reg; // Link training start pulse
    logic lrst_reg; // Internal logic held in reset

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Pull-up on in reset or when the pin is an input (dir 1 = output)
    function automatic logic pull_on(input logic rst, input logic dir_out);
        return rst | ~dir_out;
    endfunction

    // Global reset holds logic in reset; board reset also counts
    wire in_reset = i_srst | ~glob_rst_n;
    // Release edge seen: reset state with pin now high
    wire release_evt = (state_reg == ST_RESET) & glob_rst_n;
    // Serial bus role when pull-up sensed or software detect set
    wire serial_mode = strap_reg[STRAP_SCL_PULLUP] | i_serial_bus_detect_bit;
    // Per-pin pull-up enables, same decode for both pins
    wire [1:0] pullup_next = {pull_on(in_reset, i_gpio_dir_in[1]),
                              pull_on(in_reset, i_gpio_dir_in[0])};
    wire cnt_done = (cnt_reg >= LINK_CYCLES - 32'h1);

    // Sequencer next state
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ST_RESET:
            begin
                cnt_next = 32'h0;
                if (glob_rst_n)
                    state_next = ST_WAIT;
            end
            ST_WAIT:
            begin
                cnt_next = cnt_reg + 32'h1;
                if (cnt_done)
                    state_next = ST_RUN;
            end
            ST_RUN:
            begin
                state_next = ST_RUN;
            end
            default:
            begin
                state_next = ST_RESET;
                cnt_next = 32'h0;
            end
        endcase
    end

    // ----------------------------------------
    // Sequencer and strap latch
    // ----------------------------------------
    // Global reset forces sequencer back to reset state
    always_ff @(posedge i_mclk)
    begin
        if (in_reset)
        begin
            state_reg <= ST_RESET;
            cnt_reg <= 32'h0;
            strap_reg <= STRAP_RESET;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            if (release_evt)
                strap_reg <= strap_now;
        end
    end

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    // Pin roles: serial pair or general I/O, each role from its own flop
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            data_sel_reg <= 1'b0;
            clock_sel_reg <= 1'b0;
            line_three_reg <= 1'b1;
            line_four_reg <= 1'b1;
        end
        else
        begin
            data_sel_reg <= serial_mode;
            clock_sel_reg <= serial_mode;
            line_three_reg <= ~serial_mode;
            line_four_reg <= ~serial_mode;
        end
    end

    // Pull-up enables follow reset and pin direction
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            pullup_reg <= 2'h3;
        else
            pullup_reg <= pullup_next;
    end

    // ----------------------------------------
    // Strap-derived settings
    // ----------------------------------------
    // Copies of the latched straps; they move only when the latch does
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            clk66_reg <= CLK_SEL_50MHZ;
            irq_en_reg <= 1'b0;
        end
        else
        begin
            clk66_reg <= strap_reg[STRAP_CLK_SEL];
            irq_en_reg <= strap_reg[STRAP_IRQ_PULLUP];
        end
    end

    // ----------------------------------------
    // Reset and training outputs
    // ----------------------------------------
    // Bus reset and internal reset track the combined reset
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            bus_rst_n_reg <= 1'b0;
            lrst_reg <= 1'b1;
        end
        else
        begin
            bus_rst_n_reg <= ~in_reset;
            lrst_reg <= in_reset;
        end
    end

    // One-cycle training start as the wait count expires
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            train_reg <= 1'b0;
        else
            train_reg <= (state_reg == ST_WAIT) & cnt_done;
    end

    // ----------------------------------------
    // Output drive
    // ----------------------------------------
    assign o_serial_data_sel = data_sel_reg;
    assign o_serial_clock_sel = clock_sel_reg;
    assign o_general_io_line_three_sel = line_three_reg;
    assign o_general_io_line_four_sel = line_four_reg;
    assign o_gpio_pullup_en = pullup_reg;
    assign o_pci_clock_outputs_66 = clk66_reg;
    assign o_serial_interrupt_en = irq_en_reg;
    assign o_secondary_bus_reset_out_n = bus_rst_n_reg;
    assign o_link_train_start = train_reg;
    assign o_logic_reset = lrst_reg;
endmodule

// ===== tb/strap_board.sv
// Board strap resistors and system reset source
`timescale 1ns/1ns
module strap_board (
    input wire logic i_mclk,
    input wire logic i_hold,
    input wire logic [2:0] i_level,
    output logic o_glob_rst_n = 1'b0,
    output logic [2:0] o_strap = 3'h0
);
    // Pins move just after an edge
    always @(posedge i_mclk)
    begin
        o_glob_rst_n <= !i_hold;
        o_strap <= i_level;
    end
endmodule

// ===== tb/strap_pin_function_select_sva.sv
// Port checker for the strap and pin-function select block
`timescale 1ns/1ns
module strap_pin_function_select_sva
    import strap_pkg::*;
#(
    parameter logic [31:0] LINK_CYCLES = LINK_START_DELAY
)(
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_global_reset_in_n,
    input wire logic i_scl_pullup_sense,
    input wire logic i_pci_clock_freq_strap,
    input wire logic i_serial_interrupt_pin,
    input wire logic i_serial_bus_detect_bit,
    input wire logic [1:0] i_gpio_dir_in,
    input wire logic o_serial_data_sel,
    input wire logic o_serial_clock_sel,
    input wire logic o_general_io_line_three_sel,
    input wire logic o_general_io_line_four_sel,
    input wire logic [1:0] o_gpio_pullup_en,
    input wire logic o_pci_clock_outputs_66,
    input wire logic o_serial_interrupt_en,
    input wire logic o_secondary_bus_reset_out_n,
    input wire logic o_link_train_start,
    input wire logic o_logic_reset
);
    // Longest wait from reset release to training
    localparam int LW = int'(LINK_CYCLES) + 8;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    a_data_role: assert property (o_general_io_line_three_sel == !o_serial_data_sel)
        else $error("data pin has two roles");
    a_clock_role: assert property (o_serial_clock_sel == o_serial_data_sel
        && o_general_io_line_four_sel == !o_serial_clock_sel) else $error("clock pin role");
    a_live_detect: assert property ($past(i_serial_bus_detect_bit) && $past(!i_srst)
        |-> o_serial_data_sel) else $error("detect bit ignored");
    a_pull_input: assert property ($past(!o_logic_reset) && !o_logic_reset
        |-> o_gpio_pullup_en == ~$past(i_gpio_dir_in)) else $error("pull-up wrong");
    a_pull_reset: assert property (o_logic_reset && $past(o_logic_reset)
        |-> o_gpio_pullup_en == 2'h3) else $error("pull-up off in reset");
    a_reset_logic: assert property (!i_global_reset_in_n [*5] |=> o_logic_reset)
        else $error("global reset ignored");
    a_bus_reset: assert property (!i_global_reset_in_n [*5]
        |=> !o_secondary_bus_reset_out_n) else $error("bus reset not driven");
    a_strap_hold: assert property (!o_logic_reset [*3] |=> o_logic_reset
        || ($stable(o_pci_clock_outputs_66) && $stable(o_serial_interrupt_en)))
        else $error("strap result moved");
    a_train_start: assert property ($fell(o_logic_reset) |-> ##[0:LW] o_link_train_start)
        else $error("training late");
    a_train_pulse: assert property (o_link_train_start |=> !o_link_train_start)
        else $error("training pulse too long");
endmodule
bind strap_pin_function_select strap_pin_function_select_sva #(.LINK_CYCLES(LINK_CYCLES))
    u_sva (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_global_reset_in_n(i_global_reset_in_n),
    .i_scl_pullup_sense(i_scl_pullup_sense),
    .i_pci_clock_freq_strap(i_pci_clock_freq_strap),
    .i_serial_interrupt_pin(i_serial_interrupt_pin),
    .i_serial_bus_detect_bit(i_serial_bus_detect_bit),
    .i_gpio_dir_in(i_gpio_dir_in),
    .o_serial_data_sel(o_serial_data_sel),
    .o_serial_clock_sel(o_serial_clock_sel),
    .o_general_io_line_three_sel(o_general_io_line_three_sel),
    .o_general_io_line_four_sel(o_general_io_line_four_sel),
    .o_gpio_pullup_en(o_gpio_pullup_en),
    .o_pci_clock_outputs_66(o_pci_clock_outputs_66),
    .o_serial_interrupt_en(o_serial_interrupt_en),
    .o_secondary_bus_reset_out_n(o_secondary_bus_reset_out_n),
    .o_link_train_start(o_link_train_start),
    .o_logic_reset(o_logic_reset)
);

// ===== tb/strap_pin_function_select_bench.sv
// Self-checking bench for the strap and pin-function select block
`timescale 1ns/1ns
module strap_pin_function_select_bench
    import strap_pkg::*;
;
    logic mclk = 1'b0, srst = 1'b1, hold = 1'b1, det = 1'b0, glob_rst_n;
    logic [2:0] lvl = 3'h0, strap; // Strap levels wanted, and on the pins
    logic [1:0] dir = 2'h0, pull;
    logic d_sel, c_sel, t_sel, f_sel, clk66, irq_en, bus_n, train, lrst;
    int bad_count = 0, tests_run = 0, wait_n;
    strap_board u_board (.i_mclk(mclk), .i_hold(hold), .i_level(lvl), .o_glob_rst_n(glob_rst_n),
        .o_strap(strap));
    strap_pin_function_select #(.LINK_CYCLES(32'h0000_0004)) u_dut (.i_mclk(mclk),
        .i_srst(srst), .i_global_reset_in_n(glob_rst_n), .i_scl_pullup_sense(strap[0]),
        .i_pci_clock_freq_strap(strap[1]), .i_serial_interrupt_pin(strap[2]),
        .i_serial_bus_detect_bit(det), .i_gpio_dir_in(dir), .o_serial_data_sel(d_sel),
        .o_serial_clock_sel(c_sel), .o_general_io_line_three_sel(t_sel),
        .o_general_io_line_four_sel(f_sel), .o_gpio_pullup_en(pull),
        .o_pci_clock_outputs_66(clk66), .o_serial_interrupt_en(irq_en),
        .o_secondary_bus_reset_out_n(bus_n), .o_link_train_start(train), .o_logic_reset(lrst));
    // Compare one value
    task check(input logic [2:0] seen, input logic [2:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and stop
    task end_sim;
        $display("%0d mismatches in %0d compares", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Global reset with straps s, release, then check results
    task boot(input logic [2:0] s);
        @(posedge mclk) hold <= 1'b1;
        lvl <= s;
        repeat (8) @(negedge mclk);
        check({2'h0, bus_n}, 3'h0);
        check({lrst, pull}, 3'h7);
        @(posedge mclk) hold <= 1'b0;
        wait_n = 0;
        do
        begin
            @(negedge mclk);
            wait_n++;
        end
        while (train !== 1'b1 && wait_n < 40);
        check({2'h0, wait_n <= 14}, 3'h1);
        check({2'h0, d_sel}, {2'h0, s[0]});
        check({c_sel, t_sel, f_sel}, {s[0], ~s[0], ~s[0]});
        check({2'h0, clk66}, {2'h0, s[1]});
        check({2'h0, irq_en}, {2'h0, s[2]});
        @(posedge mclk) lvl <= ~s;
        repeat (8) @(negedge mclk);
        check({d_sel, clk66, irq_en}, {s[0], s[1], s[2]});
    endtask
    initial forever #2 mclk = ~mclk;
    // Watchdog: the whole sequence needs well under a tenth of this
    initial
    begin
        #40000;
        bad_count++;
        end_sim;
    end
    // Main sequence
    initial
    begin
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) boot(i[2:0]);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk) dir <= i[1:0];
            repeat (2) @(negedge mclk);
            check({1'b0, pull}, {1'b0, ~i[1:0]});
        end
        boot(3'h6);
        @(posedge mclk) det <= 1'b1;
        repeat (2) @(negedge mclk);
        check({2'h0, c_sel}, 3'h1);
        check({d_sel, t_sel, f_sel}, 3'h4);
        @(posedge mclk) det <= 1'b0;
        repeat (2) @(negedge mclk);
        check({2'h0, d_sel}, 3'h0);
        check({c_sel, t_sel, f_sel}, 3'h3);
        end_sim;
    end
endmodule
